// file: src/abk_consts.vh
// Constants for the address break comparator: register map, field positions,
// reset values and encodings. Included by the design files by bare name.
`ifndef ABK_CONSTS_VH
`define ABK_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus
`define ABK_OFF_CTRL 8'h00
`define ABK_OFF_STAT 8'h04
`define ABK_OFF_ADDR 8'h08
`define ABK_OFF_DATA 8'h0C
`define ABK_OFF_ISTAT 8'h10
`define ABK_OFF_IMASK 8'h14

// Control register fields
`define ABK_CTRL_RTI_BIT 7
`define ABK_CTRL_CSEL_HI 6
`define ABK_CTRL_CSEL_LO 5
`define ABK_CTRL_ACMP_HI 4
`define ABK_CTRL_ACMP_LO 2
`define ABK_CTRL_DCMP_HI 1
`define ABK_CTRL_DCMP_LO 0
`define ABK_CTRL_RESET 8'h80

// Status/enable register fields
`define ABK_STAT_FLAG_BIT 7
`define ABK_STAT_IE_BIT 6
`define ABK_STAT_RSVD 6'h3F

// Break address and break data reset values
`define ABK_ADDR_RESET 16'hFFFF
`define ABK_DATA_RESET 16'h0000

// Cycle select encodings
`define ABK_CSEL_EXEC 2'h0
`define ABK_CSEL_READ 2'h1
`define ABK_CSEL_WRITE 2'h2
`define ABK_CSEL_RW 2'h3

// Data compare encodings
`define ABK_DCMP_NONE 2'h0
`define ABK_DCMP_LOW 2'h1
`define ABK_DCMP_HIGH 2'h2
`define ABK_DCMP_FULL 2'h3

// Bus space encodings of the CPU access
`define ABK_SPACE_MEM 2'h0
`define ABK_SPACE_IO8 2'h1
`define ABK_SPACE_IO16 2'h2

// Interrupt status bits
`define ABK_IRQ_BREAK_BIT 0
`define ABK_IRQ_BADCFG_BIT 1
`define ABK_IRQ_WIDTH 2

// AXI responses
`define ABK_RESP_OKAY 2'h0
`define ABK_RESP_SLVERR 2'h2

`endif

// file: src/abk_match.v
// Combinational break comparator for one CPU bus cycle.
// Assumes the CPU presents a stable cycle description while cycle_end is high.
`timescale 1ns/1ps
`include "abk_consts.vh"

module abk_match
(
   // Configuration
   input wire [7:0] ctrl,
   input wire [15:0] break_address,
   input wire [15:0] break_data,
   // CPU cycle
   input wire cpu_fetch,
   input wire cpu_read,
   input wire cpu_write,
   input wire cpu_word,
   input wire [1:0] cpu_space,
   input wire [15:0] cpu_addr,
   input wire [15:0] cpu_data,
   // Result
   output wire hit
);

   // Mask of address bits taken into the compare
   function [15:0] abk_addr_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: abk_addr_mask = 16'hFFFF;
            3'h1: abk_addr_mask = 16'hFFF0;
            3'h2: abk_addr_mask = 16'hFF00;
            3'h3: abk_addr_mask = 16'hF000;
            default: abk_addr_mask = 16'h0000;
         endcase
      end
   endfunction

   wire [1:0] csel;
   wire [2:0] acmp;
   wire [1:0] dcmp;
   wire cycle_ok;
   wire addr_ok;
   wire upper_lane;
   reg data_ok;

   assign csel = ctrl[`ABK_CTRL_CSEL_HI:`ABK_CTRL_CSEL_LO];
   assign acmp = ctrl[`ABK_CTRL_ACMP_HI:`ABK_CTRL_ACMP_LO];
   assign dcmp = ctrl[`ABK_CTRL_DCMP_HI:`ABK_CTRL_DCMP_LO];

   // Cycle type filter [R2] [R4]
   assign cycle_ok = (csel == `ABK_CSEL_EXEC) ? cpu_fetch :
                     (csel == `ABK_CSEL_READ) ? cpu_read :
                     (csel == `ABK_CSEL_WRITE) ? cpu_write :
                     (cpu_read | cpu_write);

   // Prohibited 1xx settings never match [R5]
   assign addr_ok = ~acmp[2] &
                    (((cpu_addr ^ break_address) & abk_addr_mask(acmp)) == 16'h0000);

   // Byte lane carrying the data: bytes and 8-bit I/O always upper, words by address
   assign upper_lane = ~cpu_word | (cpu_space == `ABK_SPACE_IO8) | ~cpu_addr[0]; // [R8] [R9] [R10]

   always @*
   begin
      data_ok = 1'b1;
      if (csel != `ABK_CSEL_EXEC) // [R4]
      begin
         case (dcmp) // [R7]
            `ABK_DCMP_NONE: data_ok = 1'b1;
            `ABK_DCMP_LOW: data_ok = ~upper_lane & (cpu_data[7:0] == break_data[7:0]);
            `ABK_DCMP_HIGH: data_ok = upper_lane & (cpu_data[15:8] == break_data[15:8]);
            default: data_ok = (cpu_data == break_data);
         endcase
      end
   end

   assign hit = cycle_ok & addr_ok & data_ok;

endmodule

// file: src/abk_top.v
// Address break comparator: AXI4-Lite register file, break flag, CPU request.
// Assumes the CPU bus runs on aclk and pulses cpu_cycle_end once per bus cycle.
// Function
// [R1] Break request ignores CPU global interrupt mask
// [R2] Break on instruction execution or data access
// [R3] Return-irq-unmask bit7 resets 1, holds after return
// [R4] Cycle select: exec, read, write, either
// [R5] Address compare: 16, 12, 8, 4 upper bits
// [R6] Software never writes address compare 1xx
// [R7] Data compare: none, low, high, full word
// [R8] Memory lane: word odd lower, else upper
// [R9] 8-bit I/O accesses always upper lane
// [R10] 16-bit I/O lanes like memory, bytes upper
// [R11] Module standby stops this unit alone
// [R12] Flag set on match; cleared read-1-write-0
// [R13] Request CPU when flag and enable set
// [R14] Break address read/write, resets all ones
// [R15] Byte data breaks use upper break byte
// [R16] Flag set on edge ending matching cycle
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "abk_consts.vh"

module abk_top
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // CPU bus observation
   input wire cpu_cycle_end,
   input wire cpu_fetch,
   input wire cpu_read,
   input wire cpu_write,
   input wire cpu_word,
   input wire [1:0] cpu_space,
   input wire [15:0] cpu_addr,
   input wire [15:0] cpu_data,
   input wire cpu_rte_done,
   input wire cpu_insn_done,
   // Module standby
   input wire module_stop,
   // Outputs to interrupt logic
   output wire break_irq_req,
   output reg rte_irq_hold,
   output wire irq
);

   // Control and configuration state
   reg [7:0] ctrl;
   reg break_flag;
   reg break_irq_enable;
   reg flag_read_armed;
   reg [15:0] break_address;
   reg [15:0] break_data;
   reg [`ABK_IRQ_WIDTH-1:0] irq_status;
   reg [`ABK_IRQ_WIDTH-1:0] irq_mask;

   // Write channel holding registers
   reg aw_held;
   reg [7:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   wire hit;
   wire break_event;
   wire do_write;
   wire do_read;
   wire [7:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [7:0] stat_value;

   // Merges a byte-strobed write into a 16-bit register
   function [15:0] abk_merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         abk_merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
         abk_merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
      end
   endfunction

   // Whether an offset is a mapped register
   function abk_mapped;
      input [7:0] off;
      begin
         case (off)
            `ABK_OFF_CTRL, `ABK_OFF_STAT, `ABK_OFF_ADDR,
            `ABK_OFF_DATA, `ABK_OFF_ISTAT, `ABK_OFF_IMASK: abk_mapped = 1'b1;
            default: abk_mapped = 1'b0;
         endcase
      end
   endfunction

   abk_match u_match
   (
      .ctrl(ctrl),
      .break_address(break_address),
      .break_data(break_data),
      .cpu_fetch(cpu_fetch),
      .cpu_read(cpu_read),
      .cpu_write(cpu_write),
      .cpu_word(cpu_word),
      .cpu_space(cpu_space),
      .cpu_addr(cpu_addr),
      .cpu_data(cpu_data),
      .hit(hit)
   );

   // Standby freezes matching only; registers stay reachable and retained
   assign break_event = cpu_cycle_end & hit & ~module_stop; // [R11] [R16]

   // Request is not gated by any CPU mask bit
   assign break_irq_req = break_flag & break_irq_enable; // [R1] [R13]

   assign irq = |(irq_status & irq_mask);

   assign stat_value = {break_flag, break_irq_enable, `ABK_STAT_RSVD};

   // Address and data are accepted independently, then the response follows
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
   assign wr_data = w_held ? w_data : s_axi_wdata;
   assign wr_strb = w_held ? w_strb : s_axi_wstrb;
   assign do_write = (aw_held | (s_axi_awvalid & s_axi_awready)) &
                     (w_held | (s_axi_wvalid & s_axi_wready));
   assign do_read = s_axi_arvalid & s_axi_arready;

   // Write channel bookkeeping
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ABK_RESP_OKAY;
      end
      else
      begin
         if (do_write)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= abk_mapped({wr_addr[7:2], 2'h0}) ? `ABK_RESP_OKAY :
                                                              `ABK_RESP_SLVERR;
         end
         else
         begin
            if (s_axi_awvalid && s_axi_awready)
            begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
               w_strb <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // Read channel: data registered on the edge that takes the address, valid the next cycle
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ABK_RESP_OKAY;
      end
      else if (do_read)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `ABK_RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'h0})
            `ABK_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl};
            `ABK_OFF_STAT: s_axi_rdata <= {24'h000000, stat_value};
            `ABK_OFF_ADDR: s_axi_rdata <= {16'h0000, break_address}; // [R14]
            `ABK_OFF_DATA: s_axi_rdata <= {16'h0000, break_data};
            `ABK_OFF_ISTAT: s_axi_rdata <= {30'h00000000, irq_status};
            `ABK_OFF_IMASK: s_axi_rdata <= {30'h00000000, irq_mask};
            default:
            begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `ABK_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Configuration registers
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= `ABK_CTRL_RESET; // [R3]
         break_irq_enable <= 1'b0;
         break_address <= `ABK_ADDR_RESET; // [R14]
         break_data <= `ABK_DATA_RESET;
         irq_mask <= {`ABK_IRQ_WIDTH{1'b0}};
      end
      else if (do_write)
      begin
         case ({wr_addr[7:2], 2'h0})
            `ABK_OFF_CTRL:
               if (wr_strb[0])
               begin
                  ctrl <= wr_data[7:0];
               end
            `ABK_OFF_STAT:
               if (wr_strb[0])
               begin
                  break_irq_enable <= wr_data[`ABK_STAT_IE_BIT];
               end
            `ABK_OFF_ADDR: break_address <= abk_merge16(break_address, wr_data, wr_strb);
            // Byte-access breaks expect the value in the upper byte
            `ABK_OFF_DATA: break_data <= abk_merge16(break_data, wr_data, wr_strb); // [R15]
            `ABK_OFF_IMASK:
               if (wr_strb[0])
               begin
                  irq_mask <= wr_data[`ABK_IRQ_WIDTH-1:0];
               end
            default:
            begin
            end
         endcase
      end
   end

   // Break flag: set on match, cleared by writing 0 after reading it as 1
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         break_flag <= 1'b0;
         flag_read_armed <= 1'b0;
      end
      else
      begin
         if (break_event)
         begin
            break_flag <= 1'b1; // [R12] [R16]
         end
         else if (do_write && flag_read_armed && wr_strb[0] &&
                  ({wr_addr[7:2], 2'h0} == `ABK_OFF_STAT) &&
                  !wr_data[`ABK_STAT_FLAG_BIT])
         begin
            break_flag <= 1'b0; // [R12]
         end
         if (do_read && ({s_axi_araddr[7:2], 2'h0} == `ABK_OFF_STAT) && break_flag)
         begin
            flag_read_armed <= 1'b1;
         end
         else if (do_write && ({wr_addr[7:2], 2'h0} == `ABK_OFF_STAT))
         begin
            flag_read_armed <= 1'b0;
         end
      end
   end

   // Sticky interrupt status, write one to clear, set wins over clear
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_status <= {`ABK_IRQ_WIDTH{1'b0}};
      end
      else
      begin
         irq_status <= (irq_status &
                        ~((do_write && wr_strb[0] &&
                           ({wr_addr[7:2], 2'h0} == `ABK_OFF_ISTAT)) ?
                          wr_data[`ABK_IRQ_WIDTH-1:0] : {`ABK_IRQ_WIDTH{1'b0}})) |
                       {ctrl[`ABK_CTRL_ACMP_HI], break_event};
      end
   end

   // Hold interrupts after a return until one instruction completes
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rte_irq_hold <= 1'b0;
      end
      else if (cpu_rte_done && !ctrl[`ABK_CTRL_RTI_BIT])
      begin
         rte_irq_hold <= 1'b1; // [R3]
      end
      else if (cpu_insn_done)
      begin
         rte_irq_hold <= 1'b0; // [R3]
      end
   end

endmodule

// file: dv/abk_top_sva.sv
// Checker for the address break comparator top-level ports.
// Bound into every abk_top; one clock domain, reset active low.
`timescale 1ns/1ps
module abk_top_sva
(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Register bus
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // CPU side
   input wire cpu_cycle_end,
   input wire cpu_rte_done,
   input wire cpu_insn_done,
   input wire module_stop,
   input wire break_irq_req,
   input wire rte_irq_hold
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_aw;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_w;
      s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_done;
      $rose(s_axi_bvalid);
   endsequence
   AST_WR_RESP: assert property ((s_aw and s_w) |=> s_axi_bvalid)
      else $error("write response missing");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RTE_SET: assert property ($rose(rte_irq_hold) |-> $past(cpu_rte_done))
      else $error("hold without return");
   AST_RTE_CLR: assert property (rte_irq_hold && cpu_insn_done && !cpu_rte_done |=> !rte_irq_hold)
      else $error("hold outlived instruction");
   AST_REQ_SET: assert property ($rose(break_irq_req) |-> $past(cpu_cycle_end && !module_stop) || $rose(s_axi_bvalid))
      else $error("request without cause");
   AST_REQ_FALL: assert property ($fell(break_irq_req) |-> s_wr_done)
      else $error("request fell without write");
endmodule

bind abk_top abk_top_sva abk_top_sva_i (.*);

// file: dv/abk_cpu_model.sv
// CPU bus model: drives cycle attributes and instruction pulses.
// Assumes one caller process in step with aclk.
`timescale 1ns/1ps
module abk_cpu_model
(
   // Clock
   input wire aclk,
   // CPU cycle
   output reg cpu_cycle_end,
   output reg cpu_fetch,
   output reg cpu_read,
   output reg cpu_write,
   output reg cpu_word,
   output reg [1:0] cpu_space,
   output reg [15:0] cpu_addr,
   output reg [15:0] cpu_data,
   // Instruction events
   output reg cpu_rte_done,
   output reg cpu_insn_done
);
   initial
   begin
      {cpu_cycle_end, cpu_fetch, cpu_read, cpu_write, cpu_word, cpu_space} = 7'h00;
      {cpu_addr, cpu_data, cpu_rte_done, cpu_insn_done} = 34'h0;
   end
   task cyc(input f, input r, input w, input wd, input [1:0] sp, input [15:0] a,
      input [15:0] d);
      @(posedge aclk);
      {cpu_fetch, cpu_read, cpu_write, cpu_word, cpu_space} <= {f, r, w, wd, sp};
      cpu_addr <= a;
      cpu_data <= d;
      cpu_cycle_end <= 1'b1;
      @(posedge aclk);
      {cpu_cycle_end, cpu_fetch, cpu_read, cpu_write} <= 4'h0;
      // Released bus must not keep the last value
      cpu_addr <= ~a;
      cpu_data <= ~d;
   endtask
   task pulse(input r, input i);
      @(posedge aclk);
      {cpu_rte_done, cpu_insn_done} <= {r, i};
      @(posedge aclk);
      {cpu_rte_done, cpu_insn_done} <= 2'h0;
   endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the address break comparator.
// Assumes abk_top with its bound checker and the CPU bus model.
`timescale 1ns/1ps
`include "abk_consts.vh"
module testbench;
   reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   reg s_axi_rready, module_stop, msk, up;
   reg [7:0] s_axi_awaddr, s_axi_araddr;
   reg [31:0] s_axi_wdata;
   reg [3:0] s_axi_wstrb;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, cpu_space;
   wire [31:0] s_axi_rdata;
   wire cpu_cycle_end, cpu_fetch, cpu_read, cpu_write, cpu_word, cpu_rte_done;
   wire cpu_insn_done, break_irq_req, rte_irq_hold, irq;
   wire [15:0] cpu_addr, cpu_data;
   integer n_errors, n_compared, i, cs, k;
   reg [15:0] seed, bar, bd, m;
   reg [1:0] br;
   reg [33:0] expq[$];

   abk_top abk_top_i (.*);
   abk_cpu_model abk_cpu_model_i (.*);

   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   function [15:0] xs(input [15:0] x);
      reg [15:0] t;
      t = x ^ (x << 7);
      t = t ^ (t >> 9);
      xs = t ^ (t << 8);
   endfunction

   task chk(input [33:0] got, input [33:0] exp);
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task summarize;
      $display("TB: %0d compared, %0d mismatches", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task tmo(input integer n);
      if (n > 40)
      begin
         n_errors = n_errors + 1;
         summarize;
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      integer n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n = n + 1;
         tmo(n);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task rd(input [7:0] a, input [33:0] e);
      integer n;
      n = 0;
      expq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         n = n + 1;
         tmo(n);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   // Oldest expected read result against what the bus returns
   always @(posedge aclk)
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
         chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());

   task hit(input h);
      #1;
      chk({33'h0, break_irq_req}, {33'h0, h});
      chk({33'h0, irq}, {33'h0, h & msk});
      rd(`ABK_OFF_STAT, {26'h0, h, 7'h7F});
      wr(`ABK_OFF_STAT, 32'h40);
      wr(`ABK_OFF_ISTAT, 32'h3);
   endtask

   initial
   begin
      {n_errors, n_compared, seed, msk, module_stop} = {64'h0, 16'h6820, 2'b10};
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ABK_OFF_CTRL, 34'h80);
      rd(`ABK_OFF_STAT, 34'h3F);
      rd(`ABK_OFF_ADDR, 34'hFFFF);
      rd(8'h18, {`ABK_RESP_SLVERR, 32'h0});
      wr(8'h18, 32'h0);
      chk({32'h0, br}, {32'h0, `ABK_RESP_SLVERR});
      $display("TB: reset values done");
      seed = xs(seed);
      bar = seed;
      seed = xs(seed);
      bd = seed;
      wr(`ABK_OFF_ADDR, {16'h0, bar});
      rd(`ABK_OFF_ADDR, {18'h0, bar});
      wr(`ABK_OFF_DATA, {16'h0, bd});
      wr(`ABK_OFF_IMASK, 32'h1);
      wr(`ABK_OFF_STAT, 32'h40);
      for (i = 0; i < 12; i = i + 1)
      begin
         cs = i / 3;
         k = i % 3;
         wr(`ABK_OFF_CTRL, {25'h1, cs[1:0], 5'h0});
         abk_cpu_model_i.cyc(k == 0, k == 1, k == 2, 1'b1, `ABK_SPACE_MEM, bar, bd);
         hit(cs == 0 ? k == 0 : cs == 3 ? k != 0 : cs == k);
      end
      $display("TB: cycle select done");
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(`ABK_OFF_CTRL, {25'h1, 3'b010, i[2:1], 2'b00});
         m = 16'h1 << (4 * i[2:1]);
         abk_cpu_model_i.cyc(1'b0, 1'b1, 1'b0, 1'b1, `ABK_SPACE_MEM, bar ^ (i[0] ? m : m >> 1), bd);
         hit(!i[0]);
      end
      $display("TB: address compare done");
      for (i = 0; i < 128; i = i + 1)
         if (i[4:3] != 2'h3 && i[6:5] != 2'h0)
         begin
            wr(`ABK_OFF_CTRL, {25'h1, 5'b01011, i[6:5]});
            up = !i[2] || i[4:3] == 2'h1 || !i[1];
            abk_cpu_model_i.cyc(1'b0, 1'b1, 1'b0, i[2], i[4:3], {bar[15:1], i[1]},
               i[0] ? bd : ~bd);
            hit(i[0] && (i[6:5] == 2'h3 || (i[6:5] == 2'h2) == up));
         end
      $display("TB: data compare done");
      module_stop <= 1'b1;
      abk_cpu_model_i.cyc(1'b0, 1'b1, 1'b0, 1'b1, `ABK_SPACE_MEM, bar, bd);
      hit(1'b0);
      module_stop <= 1'b0;
      msk = 1'b0;
      wr(`ABK_OFF_IMASK, 32'h0);
      abk_cpu_model_i.cyc(1'b0, 1'b1, 1'b0, 1'b1, `ABK_SPACE_MEM, bar, bd);
      hit(1'b1);
      // Flag set again without a status read, so the zero write must not clear it
      abk_cpu_model_i.cyc(1'b0, 1'b1, 1'b0, 1'b1, `ABK_SPACE_MEM, bar, bd);
      wr(`ABK_OFF_STAT, 32'h40);
      #1 chk({33'h0, break_irq_req}, 34'h1);
      hit(1'b1);
      $display("TB: standby and flag done");
      wr(`ABK_OFF_CTRL, 32'h0);
      abk_cpu_model_i.pulse(1'b1, 1'b0);
      #1 chk({33'h0, rte_irq_hold}, 34'h1);
      abk_cpu_model_i.pulse(1'b0, 1'b1);
      #1 chk({33'h0, rte_irq_hold}, 34'h0);
      wr(`ABK_OFF_CTRL, 32'h80);
      abk_cpu_model_i.pulse(1'b1, 1'b0);
      #1 chk({33'h0, rte_irq_hold}, 34'h0);
      $display("TB: return hold done");
      summarize;
   end
endmodule
